/* File: include/imd_cfg.svh */
`ifndef IMD_CFG_SVH
`define IMD_CFG_SVH

`define IMD_XLEN 64
`define IMD_HALF 32
`define IMD_NREG 32
`define IMD_ZERO_REG 5'h00
`define IMD_IMM_W 16

// Multiply/divide latency and repeat figures, in processor cycles.
`define IMD_LAT_W16 7'h03
`define IMD_REP_W16 7'h02
`define IMD_LAT_W32 7'h04
`define IMD_REP_W32 7'h03
`define IMD_LAT_DW 7'h07
`define IMD_REP_DW 7'h06
`define IMD_LAT_DIVW 7'h24
`define IMD_LAT_WORD_DIVIDE_VARIANT 7'h44
`define IMD_CNT_ONE 7'h01
`define IMD_CNT_ZERO 7'h00

// Issue slip of the three-operand multiply.
`define IMD_STL3_W16 2'h1
`define IMD_STL3_W32 2'h2
`define IMD_STL3_ZERO 2'h0
`define IMD_STL3_ONE 2'h1

`endif

/* File: include/imd_pkg.sv */
`include "imd_cfg.svh"

package imd_pkg;

  typedef enum logic [2:0] {
    CLS_ALU = 3'h0,
    CLS_BR = 3'h1,
    CLS_LDST = 3'h2,
    CLS_FPLDST = 3'h3,
    CLS_FPCOMP = 3'h4
  } imd_cls_e;

  typedef enum logic [3:0] {
    ALU_ADD = 4'h0, ALU_SUB = 4'h1, ALU_AND = 4'h2, ALU_OR = 4'h3,
    ALU_XOR = 4'h4, ALU_NOR = 4'h5, ALU_SLL = 4'h6, ALU_SRL = 4'h7,
    ALU_SRA = 4'h8, ALU_MOV = 4'h9, ALU_STAL = 4'ha
  } imd_alu_e;

  typedef enum logic [3:0] {
    MD_NONE = 4'h0, MD_MULT = 4'h1, MD_MULTU = 4'h2, MD_MAC = 4'h3,
    MD_MACU = 4'h4, MD_MUL3 = 4'h5, MD_DOUBLEWORD_MULTIPLY_SIGNED = 4'h6, MD_DOUBLEWORD_MULTIPLY_UNSIGNED = 4'h7,
    MD_DIV = 4'h8, MD_DIVU = 4'h9, MD_DOUBLEWORD_DIVIDE_SIGNED = 4'ha, MD_DOUBLEWORD_DIVIDE_UNSIGNED = 4'hb,
    MD_MOVE_FROM_HIGH_RESULT = 4'hc, MD_MOVE_FROM_LOW_RESULT = 4'hd
  } imd_md_e;

  typedef enum logic {
    MDS_IDLE = 1'b0,
    MDS_RUN = 1'b1
  } imd_mds_e;

  typedef struct packed {
    logic valid;
    imd_cls_e cls;
    imd_alu_e alu;
    imd_md_e md;
    logic [4:0] rs;
    logic [4:0] rt;
    logic [4:0] rd;
    logic wen;
    logic use_imm;
    logic [`IMD_IMM_W-1:0] imm;
  } imd_req_s;

  typedef struct packed {
    logic valid;
    imd_cls_e cls;
  } imd_fpreq_s;

  typedef struct packed {
    imd_req_s req;
    logic [`IMD_XLEN-1:0] a;
    logic [`IMD_XLEN-1:0] b;
    logic [`IMD_XLEN-1:0] st;
  } imd_stage_s;

  typedef struct packed {
    logic valid;
    logic [4:0] idx;
    logic [`IMD_XLEN-1:0] data;
  } imd_wb_s;

  typedef struct packed {
    logic valid;
    logic store;
    logic [`IMD_XLEN-1:0] addr;
    logic [`IMD_XLEN-1:0] data;
  } imd_mem_s;

endpackage

/* File: hdl/imd_alu.sv */
`include "imd_cfg.svh"

module imd_alu (
  input imd_pkg::imd_alu_e i_op,
  input wire logic [`IMD_XLEN-1:0] i_a,
  input wire logic [`IMD_XLEN-1:0] i_b,
  input wire logic [5:0] i_sh,
  output logic [`IMD_XLEN-1:0] o_y
);
  import imd_pkg::*;

  // Every operation settles in one cycle; address math uses the adder.
  always_comb begin
    case (i_op)
      ALU_ADD: o_y = i_a + i_b;
      ALU_SUB: o_y = i_a - i_b;
      ALU_AND: o_y = i_a & i_b;
      ALU_OR: o_y = i_a | i_b;
      ALU_XOR: o_y = i_a ^ i_b;
      ALU_NOR: o_y = ~(i_a | i_b);
      ALU_MOV: o_y = i_b;
      ALU_SLL: o_y = i_b << i_sh;
      ALU_SRL: o_y = i_b >> i_sh;
      ALU_SRA: o_y = $unsigned($signed(i_b) >>> i_sh);
      ALU_STAL: o_y = i_b << {i_a[2:0], 3'h0};
      default: o_y = i_a + i_b;
    endcase
  end

endmodule // imd_alu

/* File: hdl/imd_muldiv.sv */
`include "imd_cfg.svh"

module imd_muldiv (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_start,
  input imd_pkg::imd_md_e i_op,
  input wire logic [`IMD_XLEN-1:0] i_a,
  input wire logic [`IMD_XLEN-1:0] i_b,
  output logic o_busy,
  output logic o_pend,
  output logic o_small,
  output logic [`IMD_XLEN-1:0] o_hi,
  output logic [`IMD_XLEN-1:0] o_lo,
  output logic [`IMD_XLEN-1:0] o_mul3
);
  import imd_pkg::*;

  imd_mds_e state_q;
  logic [6:0] lat_q;
  logic [6:0] rep_q;
  logic [`IMD_XLEN-1:0] hi_q;
  logic [`IMD_XLEN-1:0] lo_q;
  logic [`IMD_XLEN-1:0] phi_q;
  logic [`IMD_XLEN-1:0] plo_q;
  logic pwr_q;
  logic [`IMD_XLEN-1:0] mul3_q;
  logic sgn;
  logic [`IMD_XLEN-1:0] p32;
  logic [2*`IMD_XLEN-1:0] p64;
  logic [`IMD_XLEN-1:0] acc;
  logic [`IMD_XLEN-1:0] nhi;
  logic [`IMD_XLEN-1:0] nlo;
  logic commit;

  function automatic logic fits16(input logic [`IMD_XLEN-1:0] x,
                                  input logic s);
    fits16 = s ? (x[31:15] == {17{x[15]}}) : (x[31:16] == 16'h0000);
  endfunction

  function automatic logic [`IMD_XLEN-1:0] sx(input logic [31:0] x);
    sx = {{`IMD_HALF{x[31]}}, x};
  endfunction

  function automatic logic [6:0] md_cycles(input imd_md_e op,
                                           input logic s16,
                                           input logic rep);
    case (op)
      MD_MULT, MD_MULTU, MD_MAC, MD_MACU, MD_MUL3: md_cycles = s16 ?
        (rep ? `IMD_REP_W16 : `IMD_LAT_W16) :
        (rep ? `IMD_REP_W32 : `IMD_LAT_W32);
      MD_DOUBLEWORD_MULTIPLY_SIGNED, MD_DOUBLEWORD_MULTIPLY_UNSIGNED: md_cycles = rep ? `IMD_REP_DW : `IMD_LAT_DW;
      MD_DIV, MD_DIVU: md_cycles = `IMD_LAT_DIVW;
      MD_DOUBLEWORD_DIVIDE_SIGNED, MD_DOUBLEWORD_DIVIDE_UNSIGNED: md_cycles = `IMD_LAT_WORD_DIVIDE_VARIANT;
      default: md_cycles = `IMD_CNT_ONE;
    endcase
  endfunction

  // Operand size is judged at run time to pick the short timing.
  assign sgn = i_op inside {MD_MULT, MD_MAC, MD_MUL3, MD_DOUBLEWORD_MULTIPLY_SIGNED, MD_DIV,
                            MD_DOUBLEWORD_DIVIDE_SIGNED};
  assign o_small = fits16(i_a, sgn) && fits16(i_b, sgn);

  always_comb begin
    // Operands are widened before the product so no upper bits are lost.
    p32 = sgn ? 64'($signed(64'($signed(i_a[31:0])) *
                            64'($signed(i_b[31:0])))) :
                64'(i_a[31:0]) * 64'(i_b[31:0]);
    p64 = sgn ? 128'($signed(128'($signed(i_a))) *
                     $signed(128'($signed(i_b)))) :
                128'(i_a) * 128'(i_b);
    acc = {hi_q[31:0], lo_q[31:0]} + p32;
    nhi = sx(p32[63:32]);
    nlo = sx(p32[31:0]);
    case (i_op)
      MD_MAC, MD_MACU: begin
        nhi = sx(acc[63:32]);
        nlo = sx(acc[31:0]);
      end
      MD_DOUBLEWORD_MULTIPLY_SIGNED, MD_DOUBLEWORD_MULTIPLY_UNSIGNED: begin
        nhi = p64[127:64];
        nlo = p64[63:0];
      end
      MD_DIV, MD_DIVU: begin
        // A zero divisor gives all ones and keeps the dividend as remainder.
        nhi = sx(i_a[31:0]);
        nlo = {`IMD_XLEN{1'b1}};
        if (i_b[31:0] != 32'h0) begin
          nhi = sgn ? sx(32'($signed(i_a[31:0]) % $signed(i_b[31:0]))) :
                      sx(i_a[31:0] % i_b[31:0]);
          nlo = sgn ? sx(32'($signed(i_a[31:0]) / $signed(i_b[31:0]))) :
                      sx(i_a[31:0] / i_b[31:0]);
        end
      end
      MD_DOUBLEWORD_DIVIDE_SIGNED, MD_DOUBLEWORD_DIVIDE_UNSIGNED: begin
        nhi = i_a;
        nlo = {`IMD_XLEN{1'b1}};
        if (i_b != 64'h0) begin
          nhi = sgn ? 64'($signed(i_a) % $signed(i_b)) : i_a % i_b;
          nlo = sgn ? 64'($signed(i_a) / $signed(i_b)) : i_a / i_b;
        end
      end
      default: begin
        nhi = sx(p32[63:32]);
        nlo = sx(p32[31:0]);
      end
    endcase
  end

  // The unit is pipelined: a new start may overlap the last result cycle.
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      state_q <= MDS_IDLE;
      lat_q <= `IMD_CNT_ZERO;
    end else if (i_start) begin
      state_q <= MDS_RUN;
      lat_q <= 7'(md_cycles(i_op, o_small, 1'b0) - `IMD_CNT_ONE);
    end else if (lat_q != `IMD_CNT_ZERO) begin
      lat_q <= 7'(lat_q - `IMD_CNT_ONE);
      if (lat_q == `IMD_CNT_ONE) begin
        state_q <= MDS_IDLE;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      rep_q <= `IMD_CNT_ZERO;
    end else if (i_start) begin
      rep_q <= 7'(md_cycles(i_op, o_small, 1'b1) - `IMD_CNT_ONE);
    end else if (rep_q != `IMD_CNT_ZERO) begin
      rep_q <= 7'(rep_q - `IMD_CNT_ONE);
    end
  end

  // An overlapped start retires the older result at the same edge that loads the new one.
  assign commit = pwr_q && (lat_q == `IMD_CNT_ONE ||
                            (i_start && lat_q != `IMD_CNT_ZERO));

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      phi_q <= 64'h0;
      plo_q <= 64'h0;
      pwr_q <= 1'b0;
      mul3_q <= 64'h0;
    end else if (i_start) begin
      phi_q <= nhi;
      plo_q <= nlo;
      pwr_q <= i_op != MD_MUL3;
      if (i_op == MD_MUL3) begin
        mul3_q <= sx(p32[31:0]);
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      hi_q <= 64'h0;
      lo_q <= 64'h0;
    end else if (commit) begin
      hi_q <= phi_q;
      lo_q <= plo_q;
    end
  end

  assign o_busy = rep_q != `IMD_CNT_ZERO;
  assign o_pend = state_q == MDS_RUN;
  assign o_hi = hi_q;
  assign o_lo = lo_q;
  assign o_mul3 = mul3_q;

  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);

  property p_rep16;
    (i_start && i_op == MD_MULT && o_small) |=> o_busy ##1 !o_busy;
  endproperty
  a_rep16: assert property (p_rep16) else $error("short repeat wrong");

  property p_lat32;
    (i_start && i_op == MD_MAC && !o_small) |=> o_pend [*3] ##1 !o_pend;
  endproperty
  a_lat32: assert property (p_lat32) else $error("long latency wrong");

  property p_dw;
    (i_start && i_op == MD_DOUBLEWORD_MULTIPLY_UNSIGNED) |=> o_busy [*5] ##1 (!o_busy && o_pend);
  endproperty
  a_dw: assert property (p_dw) else $error("doubleword timing wrong");

  property p_div;
    (i_start && i_op == MD_DIV) |=> o_pend ##34 o_pend ##1 !o_pend;
  endproperty
  a_div: assert property (p_div) else $error("divide latency wrong");

  property p_hold;
    (i_start && i_op == MD_MUL3 && !o_pend) |=>
      ($stable(o_hi) && $stable(o_lo)) [*2];
  endproperty
  a_hold: assert property (p_hold) else $error("result pair disturbed");

endmodule // imd_muldiv

/* File: hdl/imd_top.sv */
`include "imd_cfg.svh"

module imd_top (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input imd_pkg::imd_req_s i_req,
  input imd_pkg::imd_fpreq_s i_fp,
  output logic o_int_issue,
  output logic o_fp_issue,
  output logic o_slip,
  output imd_pkg::imd_wb_s o_wb,
  output imd_pkg::imd_mem_s o_mem,
  output logic [`IMD_XLEN-1:0] o_hi,
  output logic [`IMD_XLEN-1:0] o_lo
);
  import imd_pkg::*;

  logic [`IMD_XLEN-1:0] gpr_q [`IMD_NREG];
  imd_stage_s a_q;
  imd_wb_s d_q;
  imd_mem_s dm_q;
  imd_wb_s w_q;
  logic [1:0] stl3_q;

  logic [`IMD_XLEN-1:0] rs_v;
  logic [`IMD_XLEN-1:0] rt_v;
  logic [`IMD_XLEN-1:0] imm_v;
  logic [`IMD_XLEN-1:0] alu_y;
  logic [`IMD_XLEN-1:0] algn_y;
  logic [`IMD_XLEN-1:0] a_res;
  logic int_cls;
  logic is_mf;
  logic is_start;
  logic is_mac;
  logic slip;
  logic md_start;
  logic md_busy;
  logic md_pend;
  logic md_small;
  logic [`IMD_XLEN-1:0] md_mul3;

  // Newest producer wins; the writeback stage covers the write that lands
  // in the same cycle as the read, so no result waits for the file.
  function automatic logic [`IMD_XLEN-1:0] fwd(input logic [4:0] idx);
    if (idx == `IMD_ZERO_REG) begin
      fwd = 64'h0;
    end else if (a_q.req.valid && a_q.req.wen && a_q.req.rd == idx) begin
      fwd = a_res;
    end else if (d_q.valid && d_q.idx == idx) begin
      fwd = d_q.data;
    end else if (w_q.valid && w_q.idx == idx) begin
      fwd = w_q.data;
    end else begin
      fwd = gpr_q[idx];
    end
  endfunction

  // Read stage: both read ports, bypass and decode in one pass.
  // A process rather than a continuous assignment, so that a change in any
  // stage register seen inside the function re-evaluates the read.
  always_comb begin
    rs_v = fwd(i_req.rs);
    rt_v = fwd(i_req.rt);
  end
  assign imm_v = {{(`IMD_XLEN-`IMD_IMM_W){i_req.imm[`IMD_IMM_W-1]}},
                  i_req.imm};

  assign int_cls = i_req.cls != CLS_FPCOMP;
  assign is_mf = i_req.md inside {MD_MOVE_FROM_HIGH_RESULT, MD_MOVE_FROM_LOW_RESULT};
  assign is_mac = i_req.md inside {MD_MAC, MD_MACU};
  assign is_start = i_req.md != MD_NONE && !is_mf;

  // Slip decision. A restart waits only for the repeat interval, while a
  // move or accumulate that needs the pair waits for the full latency.
  always_comb begin
    slip = 1'b0;
    if (i_req.valid && int_cls) begin
      if (is_start && md_busy) begin
        slip = 1'b1;
      end
      if ((is_mf || is_mac) && md_pend) begin
        slip = 1'b1;
      end
      if (stl3_q != `IMD_STL3_ZERO) begin
        slip = 1'b1;
      end
    end
  end

  assign o_slip = slip;
  assign o_int_issue = i_req.valid && int_cls && !slip;
  // The float slot goes alongside the integer slot in the same cycle.
  assign o_fp_issue = i_fp.valid && i_fp.cls == CLS_FPCOMP && !slip;
  assign md_start = o_int_issue && is_start;

  imd_muldiv u_md (
    .i_sys_clk(i_sys_clk),
    .i_rstn(i_rstn),
    .i_start(md_start),
    .i_op(i_req.md),
    .i_a(rs_v),
    .i_b(rt_v),
    .o_busy(md_busy),
    .o_pend(md_pend),
    .o_small(md_small),
    .o_hi(o_hi),
    .o_lo(o_lo),
    .o_mul3(md_mul3)
  );

  // The three-operand multiply holds later issue for its slip cycles.
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      stl3_q <= `IMD_STL3_ZERO;
    end else if (md_start && i_req.md == MD_MUL3) begin
      stl3_q <= md_small ? `IMD_STL3_W16 : `IMD_STL3_W32;
    end else if (stl3_q != `IMD_STL3_ZERO) begin
      stl3_q <= 2'(stl3_q - `IMD_STL3_ONE);
    end
  end

  // Execute stage register. A slip leaves a bubble here.
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      a_q <= '0;
    end else begin
      a_q.req <= i_req;
      a_q.req.valid <= o_int_issue;
      // Branches and stores write nothing; load data is outside this path.
      a_q.req.wen <= i_req.wen && i_req.cls inside {CLS_ALU} ||
                     i_req.wen && is_mf ||
                     i_req.wen && i_req.md == MD_MUL3;
      if (is_mf) begin
        a_q.req.alu <= ALU_MOV;
      end
      if (i_req.cls inside {CLS_LDST, CLS_FPLDST}) begin
        a_q.req.alu <= ALU_ADD;
      end
      a_q.a <= rs_v;
      a_q.b <= is_mf ? (i_req.md == MD_MOVE_FROM_HIGH_RESULT ? o_hi : o_lo) :
               (i_req.use_imm ? imm_v : rt_v);
      a_q.st <= rt_v;
    end
  end

  imd_alu u_alu (
    .i_op(a_q.req.alu),
    .i_a(a_q.a),
    .i_b(a_q.b),
    .i_sh(a_q.req.imm[5:0]),
    .o_y(alu_y)
  );

  // A second shifter lane aligns store data against the fresh address.
  imd_alu u_align (
    .i_op(ALU_STAL),
    .i_a(alu_y),
    .i_b(a_q.st),
    .i_sh(6'h00),
    .o_y(algn_y)
  );

  assign a_res = (a_q.req.md == MD_MUL3) ? md_mul3 : alu_y;

  // Memory stage carries the result; the data cache itself is elsewhere.
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      d_q <= '0;
    end else begin
      d_q.valid <= a_q.req.valid && a_q.req.wen &&
                   a_q.req.rd != `IMD_ZERO_REG;
      d_q.idx <= a_q.req.rd;
      d_q.data <= a_res;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      dm_q <= '0;
    end else begin
      dm_q.valid <= a_q.req.valid &&
                    a_q.req.cls inside {CLS_LDST, CLS_FPLDST};
      dm_q.store <= !a_q.req.wen;
      dm_q.addr <= alu_y;
      dm_q.data <= algn_y;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      w_q <= '0;
    end else begin
      w_q <= d_q;
    end
  end

  // Single write port; register zero is never written.
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      for (int i = 0; i < `IMD_NREG; i++) begin
        gpr_q[i] <= 64'h0;
      end
    end else if (w_q.valid && w_q.idx != `IMD_ZERO_REG) begin
      gpr_q[w_q.idx] <= w_q.data;
    end
  end

  assign o_wb = w_q;
  assign o_mem = dm_q;

  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);

  property p_zero;
    (i_req.valid && i_req.rs == `IMD_ZERO_REG) |-> rs_v == 64'h0;
  endproperty
  a_zero: assert property (p_zero) else $error("zero register nonzero");

  property p_byp;
    (o_int_issue && a_q.req.valid && a_q.req.wen &&
     a_q.req.rd == i_req.rt && i_req.rt != `IMD_ZERO_REG) |-> rt_v == a_res;
  endproperty
  a_byp: assert property (p_byp) else $error("bypass missed");

  property p_pipe;
    (o_int_issue && i_req.cls == CLS_ALU && i_req.wen &&
     i_req.rd != `IMD_ZERO_REG) |->
      ##3 (o_wb.valid && o_wb.idx == $past(i_req.rd, 3));
  endproperty
  a_pipe: assert property (p_pipe) else $error("writeback not in stage 5");

  property p_mul3;
    (md_start && i_req.md == MD_MUL3 && !md_small) |=>
      (stl3_q != `IMD_STL3_ZERO) [*2] ##1 (stl3_q == `IMD_STL3_ZERO);
  endproperty
  a_mul3: assert property (p_mul3) else $error("multiply slip wrong");

  property p_mf;
    (i_req.valid && is_mf && md_pend) |-> !o_int_issue;
  endproperty
  a_mf: assert property (p_mf) else $error("early result read");

  property p_fp;
    o_fp_issue |-> (i_fp.cls == CLS_FPCOMP && !o_slip);
  endproperty
  a_fp: assert property (p_fp) else $error("bad float issue");

endmodule // imd_top

/* File: tb/imd_issue_model.sv */
`include "imd_cfg.svh"

module imd_issue_model (
  input wire logic i_sys_clk,
  input wire logic i_issue,
  input wire logic i_fp_issue,
  output imd_pkg::imd_req_s o_req
);
  timeunit 1ns;
  timeprecision 1ps;
  import imd_pkg::*;
  localparam int RW = $bits(imd_req_s);
  int slips;
  logic fp_take;
  logic fp_slip;

  initial begin
    o_req = '0;
  end

  // The request stays put through every slipped cycle, so the block sees
  // one steady instruction until the edge that takes it.
  task automatic send(input imd_req_s r);
    int n;
    n = 0;
    fp_slip = 1'b0;
    @(negedge i_sys_clk);
    o_req = r;
    #1;
    while (!i_issue && n < 200) begin
      n++;
      fp_slip = fp_slip | i_fp_issue;
      @(negedge i_sys_clk);
      #1;
    end
    slips = n;
    fp_take = i_fp_issue;
  endtask

  // Released fields are inverted so stale values never pass for good ones.
  task automatic idle();
    @(negedge i_sys_clk);
    o_req = {1'b0, ~o_req[RW-2:0]};
  endtask
endmodule // imd_issue_model

/* File: tb/integer_mul_div_datapath_tb_top.sv */
`include "imd_cfg.svh"

module integer_mul_div_datapath_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import imd_pkg::*;
  typedef struct {
    imd_alu_e op; int rs; int rt; int rd; logic ui; logic [15:0] imm;
    logic [63:0] y;
  } imd_row_s;
  logic i_sys_clk;
  logic i_rstn;
  imd_req_s i_req;
  imd_fpreq_s i_fp;
  logic o_int_issue;
  logic o_fp_issue;
  logic o_slip;
  imd_wb_s o_wb;
  imd_mem_s o_mem;
  logic [`IMD_XLEN-1:0] o_hi;
  logic [`IMD_XLEN-1:0] o_lo;
  logic [63:0] wb_d [32];
  int wb_c [32];
  imd_mem_s mem_q;
  int cycles = 0;
  int fail_count = 0;
  int total_checks = 0;
  int t0;
  imd_row_s rows [16] = '{
    '{ALU_ADD, 0, 0, 1, 1'b1, 16'h8001, 64'hffff_ffff_ffff_8001},
    '{ALU_ADD, 0, 0, 2, 1'b1, 16'h0005, 64'h5},
    '{ALU_ADD, 1, 2, 3, 1'b0, 16'h0000, 64'hffff_ffff_ffff_8006},
    '{ALU_SUB, 2, 1, 4, 1'b0, 16'h0000, 64'h8004},
    '{ALU_AND, 1, 2, 5, 1'b0, 16'h0000, 64'h1},
    '{ALU_OR, 1, 2, 6, 1'b0, 16'h0000, 64'hffff_ffff_ffff_8005},
    '{ALU_XOR, 1, 2, 7, 1'b0, 16'h0000, 64'hffff_ffff_ffff_8004},
    '{ALU_NOR, 1, 2, 8, 1'b0, 16'h0000, 64'h7ffa},
    '{ALU_SLL, 2, 2, 10, 1'b0, 16'h0004, 64'h50},
    '{ALU_SRL, 1, 1, 11, 1'b0, 16'h0004, 64'h0fff_ffff_ffff_f800},
    '{ALU_SRA, 1, 1, 12, 1'b0, 16'h0004, 64'hffff_ffff_ffff_f800},
    '{ALU_MOV, 2, 2, 13, 1'b0, 16'h0000, 64'h5},
    '{ALU_ADD, 0, 0, 0, 1'b1, 16'h0007, 64'h0},
    '{ALU_OR, 0, 0, 14, 1'b0, 16'h0000, 64'h0},
    '{ALU_ADD, 0, 0, 20, 1'b1, 16'h0007, 64'h7},
    '{ALU_SLL, 20, 20, 21, 1'b0, 16'h0010, 64'h7_0000}};

  imd_top u_dut (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_req(i_req),
    .i_fp(i_fp), .o_int_issue(o_int_issue), .o_fp_issue(o_fp_issue),
    .o_slip(o_slip), .o_wb(o_wb), .o_mem(o_mem), .o_hi(o_hi), .o_lo(o_lo));

  imd_issue_model u_pm (.i_sys_clk(i_sys_clk), .i_issue(o_int_issue),
    .i_fp_issue(o_fp_issue), .o_req(i_req));

  initial begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end

  // Writeback and store traffic is logged so checks can run after bursts.
  always @(posedge i_sys_clk) begin
    cycles <= cycles + 1;
    if (o_wb.valid) begin
      wb_d[o_wb.idx] <= o_wb.data;
      wb_c[o_wb.idx] <= cycles;
    end
    if (o_mem.valid) begin
      mem_q <= o_mem;
    end
    if (cycles == 3000) begin
      fail_count++;
      $display("unexpected at %0t: cycle limit reached", $time);
      finish_test();
    end
  end

  function automatic imd_req_s mk(imd_cls_e c, imd_alu_e a, imd_md_e m,
    int rs, int rt, int rd, logic w, logic ui, logic [15:0] imm);
    imd_req_s r;
    r = '{1'b1, c, a, m, 5'(rs), 5'(rt), 5'(rd), w, ui, imm};
    return r;
  endfunction

  task automatic chk64(input logic [63:0] g, input logic [63:0] e);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic chki(input int g, input int e);
    total_checks++;
    if (g != e) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic md(imd_md_e m, int rs, int rt, int rd, int sl);
    u_pm.send(mk(CLS_ALU, ALU_ADD, m, rs, rt, rd, rd != 0, 1'b0, 16'h0));
    chki(u_pm.slips, sl);
  endtask

  task automatic settle(int n);
    u_pm.idle();
    repeat (n) @(negedge i_sys_clk);
  endtask

  task automatic endt(string s);
    $display("%s done: %0d checks, %0d bad", s, total_checks, fail_count);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    i_rstn = 1'b0;
    i_fp = '0;
    repeat (5) @(negedge i_sys_clk);
    i_rstn = 1'b1;
    chk64(o_hi, 64'h0);
    chk64(o_lo, 64'h0);
    chk64({63'h0, o_wb.valid}, 64'h0);
    endt("reset");
    foreach (rows[i]) begin
      u_pm.send(mk(CLS_ALU, rows[i].op, MD_NONE, rows[i].rs, rows[i].rt,
        rows[i].rd, 1'b1, rows[i].ui, rows[i].imm));
      if (i == 2) t0 = cycles;
    end
    settle(5);
    foreach (rows[i]) begin
      if (rows[i].rd != 0) chk64(wb_d[rows[i].rd], rows[i].y);
    end
    chki(wb_c[3] - t0, 3);
    endt("alu");
    md(MD_MULTU, 20, 20, 0, 0);
    md(MD_MOVE_FROM_LOW_RESULT, 0, 0, 24, 2);
    md(MD_MULTU, 21, 21, 0, 0);
    md(MD_MOVE_FROM_HIGH_RESULT, 0, 0, 25, 3);
    md(MD_MULT, 20, 20, 0, 0);
    md(MD_MULT, 20, 20, 0, 1);
    md(MD_MAC, 20, 20, 0, 2);
    md(MD_MOVE_FROM_LOW_RESULT, 0, 0, 27, 2);
    md(MD_DOUBLEWORD_MULTIPLY_SIGNED, 20, 21, 0, 0);
    md(MD_DOUBLEWORD_MULTIPLY_UNSIGNED, 20, 21, 0, 5);
    md(MD_MOVE_FROM_LOW_RESULT, 0, 0, 26, 6);
    settle(5);
    chk64(wb_d[24], 64'h31);
    chk64(wb_d[25], 64'h31);
    chk64(wb_d[27], 64'h62);
    chk64(wb_d[26], 64'h31_0000);
    endt("multiply");
    @(negedge i_sys_clk);
    i_fp = '{1'b1, CLS_FPCOMP};
    md(MD_MUL3, 20, 20, 22, 0);
    u_pm.send(mk(CLS_ALU, ALU_ADD, MD_NONE, 0, 0, 0, 1'b1, 1'b1, 16'h1));
    chki(u_pm.slips, 1);
    md(MD_MUL3, 21, 20, 23, 0);
    u_pm.send(mk(CLS_ALU, ALU_ADD, MD_NONE, 0, 0, 0, 1'b1, 1'b1, 16'h2));
    chki(u_pm.slips, 2);
    chk64({63'h0, u_pm.fp_take}, 64'h1);
    chk64({63'h0, u_pm.fp_slip}, 64'h0);
    settle(5);
    chk64(wb_d[22], 64'h31);
    chk64(wb_d[23], 64'h31_0000);
    chk64(o_lo, 64'h31_0000);
    chk64(o_hi, 64'h0);
    endt("three operand");
    md(MD_DIV, 21, 20, 0, 0);
    md(MD_MOVE_FROM_LOW_RESULT, 0, 0, 30, 35);
    md(MD_DOUBLEWORD_DIVIDE_UNSIGNED, 21, 20, 0, 0);
    md(MD_MOVE_FROM_HIGH_RESULT, 0, 0, 31, 67);
    md(MD_DIVU, 20, 0, 0, 0);
    settle(40);
    chk64(wb_d[30], 64'h1_0000);
    chk64(wb_d[31], 64'h0);
    chk64(o_lo, 64'hffff_ffff_ffff_ffff);
    chk64(o_hi, 64'h7);
    endt("divide");
    u_pm.send(mk(CLS_LDST, ALU_ADD, MD_NONE, 20, 20, 0, 1'b0, 1'b1, 16'h2));
    settle(5);
    chk64(mem_q.addr, 64'h9);
    chk64(mem_q.data, 64'h700);
    chk64({63'h0, mem_q.store}, 64'h1);
    u_pm.send(mk(CLS_FPCOMP, ALU_ADD, MD_NONE, 0, 0, 15, 1'b1, 1'b1, 16'h1));
    chki(u_pm.slips, 200);
    chk64({63'h0, o_slip}, 64'h0);
    endt("store and class");
    settle(2);
    finish_test();
  end
endmodule // integer_mul_div_datapath_tb_top
